// file: bop_params.svh
`ifndef BOP_PARAMS_SVH
`define BOP_PARAMS_SVH
// ****************************************
// Register offsets
// ****************************************
`define BOP_OFF_INSTR  8'h00
`define BOP_OFF_ACC    8'h04
`define BOP_OFF_FLAGS  8'h08
`define BOP_OFF_BANK   8'h0c
`define BOP_OFF_PTR2   8'h10
`define BOP_OFF_CTRL   8'h14
`define BOP_OFF_PC     8'h18
`define BOP_OFF_STACK  8'h1c
`define BOP_OFF_SHADOW 8'h20
`define BOP_OFF_STATE  8'h24
`define BOP_OFF_MADDR  8'h28
`define BOP_OFF_MDATA  8'h2c
// ****************************************
// Field positions and reset values
// ****************************************
`define BOP_FLAG_C     0
`define BOP_FLAG_Z     2
`define BOP_FLAG_N     4
`define BOP_CTRL_EXT   0
`define BOP_STATE_BUSY 0
`define BOP_STATE_SKIP 1
`define BOP_RST_ZERO   '0
// ****************************************
// Encodings and address map
// ****************************************
`define BOP_OP_INVERT  6'h07
`define BOP_OP_ROTATE  6'h0d
`define BOP_OP_CMPSKIP 7'h31
`define BOP_OP_RETURN  15'h0009
`define BOP_OP_MOVE    9'h1d7
`define BOP_OP_MOVE2   4'hf
`define BOP_OP_PUSH    8'hfa
`define BOP_TWO_A      4'hc
`define BOP_TWO_B      6'h3b
`define BOP_TWO_C      8'heb
`define BOP_ACCESS_LIM 8'h5f
`define BOP_ACCESS_HI  4'hf
`define BOP_IND0       12'hfef
`define BOP_IND1       12'hfe7
`define BOP_IND2       12'hfdf
`define BOP_IND_SPAN   12'h004
`define BOP_PC_STEP    21'h000002
`define BOP_RESP_OK    2'b00
`define BOP_RESP_ERR   2'b10
`endif

// file: bop_pkg.sv
package bop_pkg;
  typedef enum logic [2:0] {
    BOP_NOP, BOP_INVERT, BOP_CMPSKIP, BOP_RETURN,
    BOP_ROTATE, BOP_MOVE, BOP_PUSH
  } bop_kind_t;
  typedef enum logic [1:0] {BOP_Q1, BOP_Q2, BOP_Q3, BOP_Q4} bop_phase_t;
  typedef enum logic {BOP_IDLE, BOP_RUN} bop_state_t;
endpackage

// file: bop_decode.sv
`timescale 1ns/1ps
`include "bop_params.svh"
module bop_decode (
  input  wire logic [15:0]       word1,
  input  wire logic [15:0]       word2,
  output bop_pkg::bop_kind_t     kind,
  output logic                   two_word
);
  import bop_pkg::*;
  always_comb begin
    kind = BOP_NOP;
    if (word1[15:10] == `BOP_OP_INVERT) begin
      kind = BOP_INVERT;
    end else if (word1[15:10] == `BOP_OP_ROTATE) begin
      kind = BOP_ROTATE;
    end else if (word1[15:9] == `BOP_OP_CMPSKIP) begin
      kind = BOP_CMPSKIP;
    end else if (word1[15:1] == `BOP_OP_RETURN) begin
      kind = BOP_RETURN;
    end else if (word1[15:7] == `BOP_OP_MOVE &&
                 word2[15:12] == `BOP_OP_MOVE2) begin
      kind = BOP_MOVE;
    end else if (word1[15:8] == `BOP_OP_PUSH) begin
      kind = BOP_PUSH;
    end
    // Any two-word opcode makes a skip cost one extra cycle
    two_word = (word1[15:12] == `BOP_TWO_A) ||
               (word1[15:10] == `BOP_TWO_B) ||
               (word1[15:8] == `BOP_TWO_C);
  end
endmodule

// file: bop_alu.sv
`timescale 1ns/1ps
`include "bop_params.svh"
module bop_alu (
  input  wire bop_pkg::bop_kind_t kind,
  input  wire logic [7:0]         opnd,
  input  wire logic [7:0]         flags_in,
  output logic [7:0]              res,
  output logic [7:0]              flags_out
);
  import bop_pkg::*;
  always_comb begin
    res = opnd;
    flags_out = flags_in;
    if (kind == BOP_INVERT) begin
      res = ~opnd;
    end else if (kind == BOP_ROTATE) begin
      res = {opnd[6:0], flags_in[`BOP_FLAG_C]};
      flags_out[`BOP_FLAG_C] = opnd[7];
    end
    if (kind == BOP_INVERT || kind == BOP_ROTATE) begin
      flags_out[`BOP_FLAG_N] = res[7];
      flags_out[`BOP_FLAG_Z] = (res == 8'h00);
    end
  end
endmodule

// file: bop_exec.sv
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bop_params.svh"
module bop_exec #(
  parameter int ADDR_W = 8,
  parameter int MEM_W  = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   busy
);
  import bop_pkg::*;

  typedef struct packed {
    bop_state_t        st;
    bop_phase_t        ph;
    logic              cyc;
    logic              last;
    bop_kind_t         kind;
    logic              skip_run;
    logic [15:0]       w1;
    logic [15:0]       w2;
    logic [MEM_W-1:0]  addr;
    logic [7:0]        opnd;
    logic [7:0]        res;
    logic [7:0]        acc;
    logic [7:0]        flags;
    logic [3:0]        bank;
    logic [MEM_W-1:0]  ptr2;
    logic [20:0]       pc;
    logic [20:0]       stack_top;
    logic [7:0]        acc_sh;
    logic [7:0]        flags_sh;
    logic [3:0]        bank_sh;
    logic              ext_en;
    logic              skip_q;
    logic [15:0]       icount;
    logic [MEM_W-1:0]  maddr;
    logic              aw_v;
    logic [ADDR_W-1:0] aw_a;
    logic              w_v;
    logic [31:0]       w_d;
    logic [3:0]        w_s;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } bop_regs_t;

  localparam bop_regs_t RST_S = `BOP_RST_ZERO;

  bop_regs_t s_q;
  bop_regs_t s_d;
  logic [7:0]       mem [2**MEM_W];
  logic             mem_we;
  logic [MEM_W-1:0] mem_wa;
  logic [7:0]       mem_wd;
  logic [7:0]       mem_rd;
  logic [7:0]       mem_md;
  bop_kind_t        dec_kind;
  logic             dec_two;
  logic [7:0]       alu_res;
  logic [7:0]       alu_flags;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [MEM_W-1:0] file_addr(
    input logic [7:0] f, input logic a, input logic ext,
    input logic [3:0] bank, input logic [MEM_W-1:0] ptr);
    logic [MEM_W-1:0] r;
    if (a) begin
      r = {bank, f};
    end else if (ext && f <= `BOP_ACCESS_LIM) begin
      r = MEM_W'(ptr + MEM_W'(f));
    end else if (f <= `BOP_ACCESS_LIM) begin
      r = {4'h0, f};
    end else begin
      r = {`BOP_ACCESS_HI, f};
    end
    return r;
  endfunction

  function automatic logic is_ind(input logic [MEM_W-1:0] a);
    return (a <= `BOP_IND0 && a >= `BOP_IND0 - `BOP_IND_SPAN) ||
           (a <= `BOP_IND1 && a >= `BOP_IND1 - `BOP_IND_SPAN) ||
           (a <= `BOP_IND2 && a >= `BOP_IND2 - `BOP_IND_SPAN);
  endfunction

  function automatic logic known(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'b00 && a <= `BOP_OFF_MDATA;
  endfunction

  function automatic logic [31:0] rd_reg(
    input bop_regs_t s, input logic [ADDR_W-1:0] a, input logic [7:0] md);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `BOP_OFF_INSTR:  r = {s.w2, s.w1};
      `BOP_OFF_ACC:    r[7:0] = s.acc;
      `BOP_OFF_FLAGS:  r[7:0] = s.flags;
      `BOP_OFF_BANK:   r[3:0] = s.bank;
      `BOP_OFF_PTR2:   r[MEM_W-1:0] = s.ptr2;
      `BOP_OFF_CTRL:   r[`BOP_CTRL_EXT] = s.ext_en;
      `BOP_OFF_PC:     r[20:0] = s.pc;
      `BOP_OFF_STACK:  r[20:0] = s.stack_top;
      `BOP_OFF_SHADOW: r[19:0] = {s.bank_sh, s.flags_sh, s.acc_sh};
      `BOP_OFF_STATE: begin
        r[`BOP_STATE_BUSY] = (s.st == BOP_RUN);
        r[`BOP_STATE_SKIP] = s.skip_q;
        r[31:16] = s.icount;
      end
      `BOP_OFF_MADDR:  r[MEM_W-1:0] = s.maddr;
      `BOP_OFF_MDATA:  r[7:0] = md;
      default:         r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ****************************************
  // Decode and process
  // ****************************************
  bop_decode u_dec (
    .word1    (s_q.w1),
    .word2    (s_q.w2),
    .kind     (dec_kind),
    .two_word (dec_two)
  );

  bop_alu u_alu (
    .kind      (s_q.kind),
    .opnd      (s_q.opnd),
    .flags_in  (s_q.flags),
    .res       (alu_res),
    .flags_out (alu_flags)
  );

  assign mem_rd = mem[s_q.addr];
  assign mem_md = mem[s_q.maddr];

  assign s_axi_awready = ce && !s_q.aw_v && !s_q.bvalid;
  assign s_axi_wready  = ce && !s_q.w_v && !s_q.bvalid;
  assign s_axi_arready = ce && !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign busy          = (s_q.st == BOP_RUN);

  always_comb begin
    logic [31:0] mask;
    logic [31:0] wv;
    logic        ok;
    s_d    = s_q;
    mem_we = 1'b0;
    mem_wa = s_q.addr;
    mem_wd = s_q.res;
    mask   = 32'h0000_0000;
    wv     = 32'h0000_0000;
    ok     = 1'b0;
    // ****************************************
    // Execution, four phases per cycle
    // ****************************************
    if (s_q.st == BOP_RUN) begin
      unique case (s_q.ph)
        BOP_Q1: begin
          if (!s_q.cyc) begin
            // Discarded instruction runs as idle cycles
            s_d.kind = s_q.skip_run ? BOP_NOP : dec_kind;
            s_d.last = s_q.skip_run ? dec_two :
                       (dec_kind == BOP_RETURN ||
                        dec_kind == BOP_MOVE);
            s_d.addr = file_addr(s_q.w1[7:0], s_q.w1[8], s_q.ext_en,
                                 s_q.bank, s_q.ptr2);
            s_d.pc = s_q.pc + (dec_two ? 21'(2 * `BOP_PC_STEP)
                                       : `BOP_PC_STEP);
          end
        end
        BOP_Q2: begin
          if (s_q.kind == BOP_MOVE) begin
            s_d.addr = MEM_W'(s_q.ptr2 + MEM_W'(
                         s_q.cyc ? s_q.w2[6:0] : s_q.w1[6:0]));
          end else if (s_q.kind == BOP_PUSH) begin
            s_d.opnd = s_q.w1[7:0];
            s_d.addr = s_q.ptr2;
          end else begin
            s_d.opnd = mem_rd;
          end
        end
        BOP_Q3: begin
          // Move keeps the byte read in its first cycle
          if (s_q.kind != BOP_MOVE) begin
            s_d.res = alu_res;
          end
          s_d.flags = alu_flags;
        end
        BOP_Q4: begin
          unique case (s_q.kind)
            BOP_INVERT, BOP_ROTATE: begin
              if (s_q.w1[9]) begin
                mem_we = 1'b1;
              end else begin
                s_d.acc = s_q.res;
              end
            end
            BOP_CMPSKIP: begin
              s_d.skip_q = (s_q.opnd == s_q.acc);
            end
            BOP_RETURN: begin
              if (!s_q.cyc) begin
                s_d.pc = s_q.stack_top;
                if (s_q.w1[0]) begin
                  s_d.acc   = s_q.acc_sh;
                  s_d.flags = s_q.flags_sh;
                  s_d.bank  = s_q.bank_sh;
                end
              end
            end
            BOP_MOVE: begin
              if (!s_q.cyc) begin
                s_d.res = is_ind(s_q.addr) ? 8'h00 : mem_rd;
              end else begin
                mem_we = !is_ind(s_q.addr);
              end
            end
            BOP_PUSH: begin
              mem_we = 1'b1;
              mem_wd = s_q.opnd;
              s_d.ptr2 = MEM_W'(s_q.ptr2 - MEM_W'(1));
            end
            BOP_NOP: begin
            end
          endcase
          s_d.icount = s_q.icount + 16'h0001;
          if (s_q.cyc == s_q.last) begin
            s_d.st = BOP_IDLE;
          end
          s_d.cyc = 1'b1;
        end
      endcase
      s_d.ph = bop_phase_t'(s_q.ph + 2'd1);
    end
    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_v = 1'b1;
      s_d.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_v = 1'b1;
      s_d.w_d = s_axi_wdata;
      s_d.w_s = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Core state is locked while an instruction runs
    if (s_q.aw_v && s_q.w_v && !s_q.bvalid) begin
      for (int i = 0; i < 4; i++) begin
        mask[8*i +: 8] = {8{s_q.w_s[i]}};
      end
      wv = (rd_reg(s_q, s_q.aw_a, mem_md) & ~mask) | (s_q.w_d & mask);
      ok = known(s_q.aw_a) && s_q.st == BOP_IDLE &&
           s_q.aw_a != `BOP_OFF_PC && s_q.aw_a != `BOP_OFF_STATE;
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = ok ? `BOP_RESP_OK : `BOP_RESP_ERR;
      if (ok) begin
        unique case (s_q.aw_a)
          `BOP_OFF_INSTR: begin
            s_d.w1 = wv[15:0];
            s_d.w2 = wv[31:16];
            s_d.st = BOP_RUN;
            s_d.ph = BOP_Q1;
            s_d.cyc = 1'b0;
            s_d.skip_run = s_q.skip_q;
            s_d.skip_q = 1'b0;
          end
          `BOP_OFF_ACC:    s_d.acc = wv[7:0];
          `BOP_OFF_FLAGS:  s_d.flags = wv[7:0];
          `BOP_OFF_BANK:   s_d.bank = wv[3:0];
          `BOP_OFF_PTR2:   s_d.ptr2 = wv[MEM_W-1:0];
          `BOP_OFF_CTRL:   s_d.ext_en = wv[`BOP_CTRL_EXT];
          `BOP_OFF_STACK:  s_d.stack_top = wv[20:0];
          `BOP_OFF_SHADOW: begin
            s_d.acc_sh = wv[7:0];
            s_d.flags_sh = wv[15:8];
            s_d.bank_sh = wv[19:16];
          end
          `BOP_OFF_MADDR:  s_d.maddr = wv[MEM_W-1:0];
          `BOP_OFF_MDATA: begin
            mem_we = 1'b1;
            mem_wa = s_q.maddr;
            mem_wd = wv[7:0];
          end
          default: begin
          end
        endcase
      end
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_reg(s_q, s_axi_araddr, mem_md);
      s_d.rresp = known(s_axi_araddr) ? `BOP_RESP_OK : `BOP_RESP_ERR;
    end
  end

  // ****************************************
  // State and data memory
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= RST_S;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Memory has no reset; software loads it through the data window
  always_ff @(posedge aclk) begin
    if (ce && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end
endmodule

// file: bop_exec_checker.sv
`timescale 1ns/1ps
// ****************************************
// Bus and timing checks
// ****************************************
module bop_exec_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              ce,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              busy
);
  import bop_pkg::*;
  logic aw_q;
  logic w_q;
  logic aw_t;
  logic w_t;
  logic both;
  assign aw_t = s_axi_awvalid && s_axi_awready;
  assign w_t  = s_axi_wvalid && s_axi_wready;
  assign both = (aw_q || aw_t) && (w_q || w_t);
  // Halves of a write may arrive apart, so each is remembered
  always_ff @(posedge aclk) begin
    if (!aresetn || both) begin
      aw_q <= 1'b0;
      w_q  <= 1'b0;
    end else begin
      aw_q <= aw_q || aw_t;
      w_q  <= w_q || w_t;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  a_read_ans: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h2c |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_write_ans: assert property (both |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_no_take: assert property (s_axi_bvalid || s_axi_rvalid |->
    !(s_axi_bvalid && (s_axi_awready || s_axi_wready)) &&
    !(s_axi_rvalid && s_axi_arready)) else $error("ready while answering");
  a_ce_freeze: assert property (!ce |=> $stable(busy))
    else $error("state moved without enable");
  a_busy_min: assert property ($rose(busy) |-> busy[*3])
    else $error("instruction too short");
  a_busy_max: assert property ($rose(busy) |-> ##[4:12] !busy)
    else $error("instruction too long");
  a_busy_start: assert property ($rose(busy) |-> $rose(s_axi_bvalid))
    else $error("busy without accepted write");
endmodule
bind bop_exec bop_exec_checker #(.ADDR_W(ADDR_W)) bop_exec_checker_inst (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);

// file: byte_op_instruction_exec_tb.sv
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module byte_op_instruction_exec_tb;
  import bop_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, busy;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [33:0] e;
  logic [7:0] v, r;
  int n_fail = 0, n_compared = 0, n1, n;
  bop_exec bop_exec_inst (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task test_done;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, x);
    end
  endtask
  // Answers are matched to the oldest note, so order must be kept
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      cmp({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()}, "bresp");
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
      e = rq.pop_front();
      cmp(s_axi_rdata, e[31:0], "rdata");
      cmp({30'h0, s_axi_rresp}, {30'h0, e[33:32]}, "rresp");
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] x = 2'b00);
    logic ad, wd;
    ad = 0;
    wd = 0;
    bq.push_back(x);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 0;
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] x = 2'b00);
    rq.push_back({x, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (!(s_axi_arvalid && s_axi_arready));
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
  endtask
  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    axw(8'h28, {20'h0, a});
    axw(8'h2c, {24'h0, d});
  endtask
  task automatic mr(input logic [11:0] a, input logic [7:0] d);
    axw(8'h28, {20'h0, a});
    axr(8'h2c, {24'h0, d});
  endtask
  task automatic idle(output int c);
    c = 0;
    while (busy === 1'b1 && c < 40) begin
      @(posedge aclk);
      c++;
    end
    if (busy === 1'b1) begin
      n_fail++;
      $display("unexpected at %0t: instruction never ended", $time);
    end
  endtask
  task automatic run(input logic [31:0] w, output int c);
    axw(8'h00, w);
    idle(c);
  endtask
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
  initial begin
    void'($urandom(32'hdc1a));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++)
      axr(i == 4 ? 8'h18 : 8'(8'h04 + 4 * i), 0);
    axr(8'h30, 0, 2'b10);
    axw(8'h18, 1, 2'b10);
    axw(8'h24, 1, 2'b10);
    ce <= 0;
    repeat (3) @(posedge aclk);
    ce <= 1;
    for (int i = 0; i < 2; i++) begin
      v = i ? 8'h00 : 8'($urandom);
      mw(12'h013, v);
      axw(8'h08, 1);
      run(32'h1c13, n1);
      cmp(n1, 4, "one cycle length");
      r = ~v;
      axr(8'h04, {24'h0, r});
      axr(8'h08, {27'h0, r[7], 1'b0, r == 0, 2'b01});
    end
    axw(8'h0c, 2);
    v = 8'($urandom);
    mw(12'h240, v);
    // Enable low mid-instruction must stretch it by the frozen cycles
    axw(8'h00, 32'h1f40);
    ce <= 0;
    repeat (3) @(posedge aclk);
    ce <= 1;
    idle(n);
    cmp(n, n1, "frozen by enable");
    mr(12'h240, ~v);
    for (int i = 0; i < 3; i++) begin
      v = i < 2 ? 8'h80 : 8'($urandom);
      mw(12'h020, v);
      axw(8'h08, i == 0);
      run(32'h3620, n);
      r = {v[6:0], i == 0};
      mr(12'h020, r);
      axr(8'h08, {27'h0, r[7], 1'b0, r == 0, 1'b0, v[7]});
    end
    v = 8'($urandom);
    axw(8'h04, v);
    mw(12'h021, v);
    axw(8'h08, 8'h15);
    run(32'h6221, n);
    axr(8'h08, 8'h15);
    run(32'h1c21, n);
    axr(8'h04, v);
    cmp(n, n1, "one word skip");
    run(32'h6221, n);
    run(32'hf07f_eb85, n);
    cmp(n, n1 + 4, "two word skip");
    mw(12'h021, v ^ 8'h01);
    run(32'h6221, n);
    run(32'h1c21, n);
    axr(8'h04, {24'h0, ~(v ^ 8'h01)});
    axw(8'h1c, 32'h001234);
    axw(8'h20, 32'h00030a5a);
    run(32'h0012, n);
    axr(8'h18, 32'h1234);
    axr(8'h04, {24'h0, ~(v ^ 8'h01)});
    run(32'h0013, n);
    cmp(n, n1 + 4, "return length");
    for (int i = 0; i < 3; i++)
      axr(8'(8'h04 + 4 * i),
          i == 0 ? 8'h5a : (i == 1 ? 8'h0a : 8'h03));
    axw(8'h00, 32'h0013);
    // Writes are refused mid-instruction to avoid racing the core
    axw(8'h04, 32'h77, 2'b10);
    idle(n);
    axw(8'h14, 1);
    axw(8'h0c, 0);
    axw(8'h10, 32'h100);
    v = 8'($urandom);
    mw(12'h105, v);
    run(32'h1e05, n);
    mr(12'h105, ~v);
    axw(8'h10, 32'hf80);
    mw(12'hf85, v);
    mw(12'hff0, ~v);
    // Destination kept off the pc low byte and the stack top bytes
    run(32'hf070_eb85, n);
    cmp(n, n1 + 4, "move length");
    mr(12'hff0, v);
    mw(12'hf90, 8'h5a);
    run(32'hf010_ebef, n);
    mr(12'hf90, 8'h00);
    mw(12'hfe7, 8'ha5);
    run(32'hf067_eb85, n);
    mr(12'hfe7, 8'ha5);
    axw(8'h10, 32'h1ec);
    v = 8'($urandom);
    run({24'h00fa, v}, n);
    cmp(n, n1, "push length");
    mr(12'h1ec, v);
    axr(8'h10, 32'h1eb);
    test_done;
  end
endmodule
